// ### tb/far_side_model.sv
// Purpose: Peer core, supply comparator, core sleep and event channels
// Assumes: Every output changes by NBA just after a rising edge
// Notes: Channels idle low; a pulse lasts exactly one cycle
`timescale 1ns/10ps
module far_side_model (
  input wire logic clk,
  output logic warn,
  output logic comp_on,
  output logic sleeping,
  output logic peer_req,
  output logic [power_mode_pkg::CHAN_COUNT-1:0] chans
);
  localparam int N = power_mode_pkg::CHAN_COUNT;
  initial begin
    warn = 1'b0;
    comp_on = 1'b0;
    sleeping = 1'b0;
    peer_req = 1'b0;
    chans = '0;
  end
  task automatic supply(input logic low, input logic on);
    @(posedge clk);
    warn <= low;
    comp_on <= on;
  endtask
  task automatic peer(input logic r);
    @(posedge clk);
    peer_req <= r;
  endtask
  task automatic sleep(input logic s);
    @(posedge clk);
    sleeping <= s;
  endtask
  // One-cycle pulse, then channels idle again
  task automatic pulse(input int ch);
    @(posedge clk);
    chans <= {{(N-1){1'b0}}, 1'b1} << ch;
    @(posedge clk);
    chans <= '0;
  endtask
endmodule // far_side_model

// ### tb/tb_top.sv
// Purpose: Register-level test of the per-core power mode block
// Assumes: Zero-wait AHB slave, hready fed back from hreadyout
// Notes: Outputs are checked 1 ns after an edge, bus read data and hresp at the edge itself, at least one cycle past the one that updates them
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] EN = 32'h8000_0000;
  localparam logic [11:0] RST_OFS [7] = '{12'h0f8, 12'h0fc, 12'h108,
    12'h188, 12'h194, 12'h198, 12'h300};
  logic hclk = 1'b0;
  logic hresetn, retain_resetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, warn, comp_on, sleeping, peer_req;
  logic req_q, mode_q, irq_q;
  logic [255:0] chans, pub_q, pub_seen;
  int bad_count = 0;
  int n_tests = 0;
  int pub_n = 0;
  int p0;
  always #5 hclk = ~hclk;
  power_mode_request_event_regs dut_u (.hclk(hclk), .hresetn(hresetn),
    .retain_resetn(retain_resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .supply_fail_comparator_warn(warn),
    .supply_fail_comparator_on(comp_on), .cpu_sleeping(sleeping),
    .peer_fixed_latency_request(peer_req), .event_channels(chans),
    .fixed_latency_request_q(req_q), .mode_fixed_latency_q(mode_q),
    .irq_q(irq_q), .publish_channels_q(pub_q));
  far_side_model far_u (.clk(hclk), .warn(warn), .comp_on(comp_on),
    .sleeping(sleeping), .peer_req(peer_req), .chans(chans));
  // Last published pattern and number of publish cycles
  always @(posedge hclk) begin
    if (|pub_q) begin
      pub_seen <= pub_q;
      pub_n <= pub_n + 1;
    end
  end
  task automatic test_done;
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Single AHB transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= power_mode_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [11:0] a,
      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic bit_chk(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    test_done();
  end
  initial begin
    hresetn = 1'b0;
    retain_resetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    retain_resetn <= 1'b1;
    foreach (RST_OFS[i]) rd("reset_val", RST_OFS[i], 32'h0);
    wr(12'h200, 32'hffff_ffff);
    rd("unmapped", 12'h200, 32'h0);
    wr(12'h078, 32'h1);
    tick(1);
    bit_chk("req_fixed", 1'b1, req_q);
    bit_chk("mode_own", 1'b1, mode_q);
    wr(12'h07c, 32'h1);
    tick(1);
    bit_chk("req_var", 1'b0, req_q);
    bit_chk("mode_var", 1'b0, mode_q);
    far_u.peer(1'b1);
    tick(3);
    bit_chk("mode_peer", 1'b1, mode_q);
    bit_chk("req_peer", 1'b0, req_q);
    far_u.peer(1'b0);
    tick(3);
    bit_chk("mode_none", 1'b0, mode_q);
    wr(12'h0f8, EN | 32'h5);
    rd("fixed_sub", 12'h0f8, EN | 32'h5);
    far_u.pulse(6);
    tick(2);
    bit_chk("sub_other", 1'b0, req_q);
    far_u.pulse(5);
    tick(2);
    bit_chk("sub_fixed", 1'b1, req_q);
    wr(12'h0fc, 32'h9);
    far_u.pulse(9);
    tick(2);
    bit_chk("sub_var_off", 1'b1, req_q);
    wr(12'h0fc, EN | 32'h9);
    far_u.pulse(9);
    tick(2);
    bit_chk("sub_var", 1'b0, req_q);
    wr(12'h0f8, 32'h5);
    far_u.pulse(5);
    tick(2);
    bit_chk("sub_fixed_off", 1'b0, req_q);
    wr(12'h188, EN | 32'd20);
    p0 = pub_n;
    far_u.supply(1'b1, 1'b0);
    tick(6);
    rd("warn_off", 12'h108, 32'h0);
    far_u.supply(1'b1, 1'b1);
    tick(6);
    rd("warn_on", 12'h108, 32'h1);
    chk("warn_pub_n", p0 + 1, pub_n);
    bit_chk("warn_pub_ch", 1'b1, pub_seen[20]);
    chk("warn_pub_bits", 32'h1, $countones(pub_seen));
    wr(12'h194, EN | 32'd30);
    wr(12'h198, EN | 32'd31);
    far_u.sleep(1'b1);
    tick(2);
    rd("sleep_in", 12'h114, 32'h1);
    rd("no_exit", 12'h118, 32'h0);
    bit_chk("pub_in", 1'b1, pub_seen[30]);
    far_u.sleep(1'b0);
    tick(2);
    rd("sleep_out", 12'h118, 32'h1);
    bit_chk("pub_out", 1'b1, pub_seen[31]);
    bit_chk("irq_masked", 1'b0, irq_q);
    wr(12'h304, 32'h2);
    tick(1);
    bit_chk("irq_entry", 1'b1, irq_q);
    rd("irq_en", 12'h300, 32'h2);
    rd("irq_set", 12'h304, 32'h2);
    wr(12'h114, 32'h0);
    tick(1);
    bit_chk("irq_cleared", 1'b0, irq_q);
    wr(12'h304, 32'h5);
    wr(12'h308, 32'h1);
    rd("irq_clr", 12'h308, 32'h6);
    wr(12'h304, 32'h0);
    rd("set_zero", 12'h300, 32'h6);
    tick(1);
    bit_chk("irq_exit", 1'b1, irq_q);
    wr(12'h118, 32'h0);
    tick(1);
    bit_chk("irq_exit_clr", 1'b0, irq_q);
    wr(12'h51c, 32'h5a5a_1234);
    far_u.supply(1'b0, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    tick(2);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd("scratch", 12'h51c, 32'h5a5a_1234);
    rd("warn_rst", 12'h108, 32'h0);
    rd("pub_rst", 12'h188, 32'h0);
    rd("irq_en_rst", 12'h300, 32'h0);
    // Supply drops while the comparator is already on
    p0 = pub_n;
    far_u.supply(1'b0, 1'b1);
    tick(4);
    far_u.supply(1'b1, 1'b1);
    tick(6);
    rd("warn_drop", 12'h108, 32'h1);
    chk("pub_off", p0, pub_n);
    test_done();
  end
endmodule // tb_top

// ### verilog/channel_route.sv
// Purpose: Event channel select for one subscribe or publish setting
// Assumes: Channel pulses are one cycle wide, on the block clock
// Notes: Purely combinational

`timescale 1ns/10ps

module channel_route (
  input power_mode_pkg::chan_cfg_t cfg,
  input logic [power_mode_pkg::CHAN_COUNT-1:0] chans,
  input logic fire,
  output logic hit,
  output logic [power_mode_pkg::CHAN_COUNT-1:0] onehot
);

  assign hit = cfg.en & chans[cfg.idx];

  genvar g;
  generate
    for (g = 0; g < power_mode_pkg::CHAN_COUNT; g++) begin : g_chan
      // Index widened, not the genvar cut
      assign onehot[g] = fire & cfg.en &
        (int'(cfg.idx) == g);
    end
  endgenerate

endmodule // channel_route

// ### verilog/power_mode_pkg.sv
// Purpose: Shared constants and types of the per-core power mode block
// Assumes: 32-bit AHB-Lite register bus, 256 event channels
// Notes: Offsets are byte addresses within the block

package power_mode_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CHAN_COUNT = 256;
  localparam int unsigned CHAN_IDX_W = 8;
  localparam int unsigned EVENT_COUNT = 3;
  localparam int unsigned SUB_COUNT = 2;
  localparam int unsigned SCRATCH_COUNT = 2;

  localparam logic [11:0] OFS_FIXED_TRIG = 12'h078;
  localparam logic [11:0] OFS_VAR_TRIG = 12'h07c;
  localparam logic [11:0] OFS_FIXED_SUB = 12'h0f8;
  localparam logic [11:0] OFS_VAR_SUB = 12'h0fc;
  localparam logic [11:0] OFS_SUPPLY_EV = 12'h108;
  localparam logic [11:0] OFS_ENTRY_EV = 12'h114;
  localparam logic [11:0] OFS_EXIT_EV = 12'h118;
  localparam logic [11:0] OFS_SUPPLY_PUB = 12'h188;
  localparam logic [11:0] OFS_ENTRY_PUB = 12'h194;
  localparam logic [11:0] OFS_EXIT_PUB = 12'h198;
  localparam logic [11:0] OFS_IRQ_EN = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFS_SCRATCH = 12'h51c;

  // Field positions
  localparam int unsigned CFG_EN_BIT = 31;
  localparam int unsigned TASK_BIT = 0;
  localparam int unsigned EVENT_BIT = 0;
  localparam int unsigned EV_SUPPLY = 0;
  localparam int unsigned EV_ENTRY = 1;
  localparam int unsigned EV_EXIT = 2;
  localparam int unsigned SUB_FIXED = 0;
  localparam int unsigned SUB_VAR = 1;

  // Reset values
  localparam logic [2:0] EVENT_RESET = 3'h0;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic en;
    logic [CHAN_IDX_W-1:0] idx;
  } chan_cfg_t;

  localparam chan_cfg_t CFG_RESET = '0;

  typedef struct packed {
    logic warn_s1;
    logic warn_s2;
    logic warn_prev;
    logic en_s1;
    logic en_s2;
    logic en_prev;
    logic sleep_prev;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic resp;
    chan_cfg_t [SUB_COUNT-1:0] sub;
    chan_cfg_t [EVENT_COUNT-1:0] pub;
    logic [EVENT_COUNT-1:0] ev;
    logic [EVENT_COUNT-1:0] irq_en;
    logic fixed_req;
    logic mode_fixed;
    logic irq;
    logic [CHAN_COUNT-1:0] pub_chan;
  } state_t;

  function automatic logic [DATA_W-1:0] cfg_to_word(chan_cfg_t c);
    cfg_to_word = '0;
    cfg_to_word[CFG_EN_BIT] = c.en;
    cfg_to_word[CHAN_IDX_W-1:0] = c.idx;
  endfunction

  function automatic chan_cfg_t word_to_cfg(logic [DATA_W-1:0] w);
    word_to_cfg.en = w[CFG_EN_BIT];
    word_to_cfg.idx = w[CHAN_IDX_W-1:0];
  endfunction

endpackage

// ### verilog/power_mode_request_event_regs.sv
// Purpose: Per-core power mode requests, events and event routing
// Assumes: Peer request and channel pulses come from hclk logic
// Notes: Comparator pins are asynchronous and synchronised here

`timescale 1ns/10ps

// Behaviour
// - One instance per core; each drives its own request
// - Fixed latency is granted whenever any core asks for it
// - Supply warning is one shared input seen by all cores alike
// - Warning event only while the supply comparator is enabled
// - Task write at 0x78 requests fixed latency
// - Task write at 0x7C requests variable latency, dropping fixed
// - Subscribe 0xF8: enabled channel pulse triggers fixed latency task
// - Subscribe 0xFC: enabled channel pulse triggers variable latency
// - Warning event register at 0x108 reads 1 once raised, resets 0
// - Sleep entry event at 0x114 set on entering sleep
// - Sleep exit event at 0x118 set on leaving sleep
// - Publish 0x188 drives warning onto chosen channel when enabled
// - Publish 0x194 and 0x198 route sleep entry and exit events
// - Interrupt enable at 0x300 with set 0x304 and clear 0x308
// - Scratch registers from 0x51C survive the block reset
// - Subscribe, publish and warning event registers reset to zero
// - Warning on supply drop, enable while low, or threshold raise
// - Set alias: ones enable, zeros ignored, reads show enables
module power_mode_request_event_regs (
  input logic hclk,
  input logic hresetn,
  input logic retain_resetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input logic supply_fail_comparator_warn,
  input logic supply_fail_comparator_on,
  input logic cpu_sleeping,
  input logic peer_fixed_latency_request,
  input logic [power_mode_pkg::CHAN_COUNT-1:0] event_channels,
  output logic fixed_latency_request_q,
  output logic mode_fixed_latency_q,
  output logic irq_q,
  output logic [power_mode_pkg::CHAN_COUNT-1:0] publish_channels_q
);

  power_mode_pkg::state_t s_q;
  power_mode_pkg::state_t s_d;
  logic [31:0] scratch_q [power_mode_pkg::SCRATCH_COUNT];
  logic [power_mode_pkg::SUB_COUNT-1:0] sub_hit;
  logic [power_mode_pkg::EVENT_COUNT-1:0] ev_fire;
  logic [power_mode_pkg::CHAN_COUNT-1:0] pub_hot
    [power_mode_pkg::EVENT_COUNT];
  logic addr_phase;
  logic warn_seen;
  logic go_fixed;
  logic go_var;

  function automatic logic [11:0] scratch_ofs(int unsigned i);
    scratch_ofs = power_mode_pkg::OFS_SCRATCH + 12'(4 * i);
  endfunction

  assign addr_phase = hsel && hready &&
    (htrans == power_mode_pkg::HTRANS_NONSEQ);

  // Drop, late enable or raised threshold
  assign warn_seen = s_q.en_s2 && s_q.warn_s2 &&
    !(s_q.en_prev && s_q.warn_prev);

  assign ev_fire[power_mode_pkg::EV_SUPPLY] = warn_seen;
  assign ev_fire[power_mode_pkg::EV_ENTRY] = cpu_sleeping && !s_q.sleep_prev;
  assign ev_fire[power_mode_pkg::EV_EXIT] = !cpu_sleeping && s_q.sleep_prev;

  genvar gs;
  generate
    for (gs = 0; gs < power_mode_pkg::SUB_COUNT; gs++) begin : g_sub
      channel_route u_sub (
        .cfg(s_q.sub[gs]),
        .chans(event_channels),
        .fire(1'b0),
        .hit(sub_hit[gs]),
        .onehot()
      );
    end
  endgenerate

  genvar gp;
  generate
    for (gp = 0; gp < power_mode_pkg::EVENT_COUNT; gp++) begin : g_pub
      channel_route u_pub (
        .cfg(s_q.pub[gp]),
        .chans(event_channels),
        .fire(ev_fire[gp]),
        .hit(),
        .onehot(pub_hot[gp])
      );
    end
  endgenerate

  always_comb begin
    logic [31:0] rd;
    logic wr_fixed;
    logic wr_var;
    rd = '0;
    wr_fixed = 1'b0;
    wr_var = 1'b0;
    s_d = s_q;
    s_d.warn_s1 = supply_fail_comparator_warn;
    s_d.warn_s2 = s_q.warn_s1;
    s_d.warn_prev = s_q.warn_s2;
    s_d.en_s1 = supply_fail_comparator_on;
    s_d.en_s2 = s_q.en_s1;
    s_d.en_prev = s_q.en_s2;
    s_d.sleep_prev = cpu_sleeping;

    // Data phase of a write
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        power_mode_pkg::OFS_FIXED_TRIG: wr_fixed = hwdata[power_mode_pkg::TASK_BIT];
        power_mode_pkg::OFS_VAR_TRIG: wr_var = hwdata[power_mode_pkg::TASK_BIT];
        power_mode_pkg::OFS_FIXED_SUB: begin
          s_d.sub[power_mode_pkg::SUB_FIXED] =
            power_mode_pkg::word_to_cfg(hwdata);
        end
        power_mode_pkg::OFS_VAR_SUB: begin
          s_d.sub[power_mode_pkg::SUB_VAR] =
            power_mode_pkg::word_to_cfg(hwdata);
        end
        power_mode_pkg::OFS_SUPPLY_EV: begin
          s_d.ev[power_mode_pkg::EV_SUPPLY] = hwdata[power_mode_pkg::EVENT_BIT];
        end
        power_mode_pkg::OFS_ENTRY_EV: begin
          s_d.ev[power_mode_pkg::EV_ENTRY] = hwdata[power_mode_pkg::EVENT_BIT];
        end
        power_mode_pkg::OFS_EXIT_EV: begin
          s_d.ev[power_mode_pkg::EV_EXIT] = hwdata[power_mode_pkg::EVENT_BIT];
        end
        power_mode_pkg::OFS_SUPPLY_PUB: begin
          s_d.pub[power_mode_pkg::EV_SUPPLY] =
            power_mode_pkg::word_to_cfg(hwdata);
        end
        power_mode_pkg::OFS_ENTRY_PUB: begin
          s_d.pub[power_mode_pkg::EV_ENTRY] =
            power_mode_pkg::word_to_cfg(hwdata);
        end
        power_mode_pkg::OFS_EXIT_PUB: begin
          s_d.pub[power_mode_pkg::EV_EXIT] =
            power_mode_pkg::word_to_cfg(hwdata);
        end
        power_mode_pkg::OFS_IRQ_EN: s_d.irq_en = hwdata[2:0];
        power_mode_pkg::OFS_IRQ_SET: s_d.irq_en = s_q.irq_en | hwdata[2:0];
        power_mode_pkg::OFS_IRQ_CLR: s_d.irq_en = s_q.irq_en & ~hwdata[2:0];
        default: ;
      endcase
    end

    // Hardware set wins over a clearing write
    s_d.ev = s_d.ev | ev_fire;

    // Own request, fixed wins a same-cycle tie
    go_fixed = wr_fixed || sub_hit[power_mode_pkg::SUB_FIXED];
    go_var = wr_var || sub_hit[power_mode_pkg::SUB_VAR];
    if (go_fixed) begin
      s_d.fixed_req = 1'b1;
    end else if (go_var) begin
      s_d.fixed_req = 1'b0;
    end
    // Any core asking forces fixed latency
    s_d.mode_fixed = s_d.fixed_req || peer_fixed_latency_request;
    s_d.irq = |(s_d.ev & s_d.irq_en);
    s_d.pub_chan = pub_hot[0] | pub_hot[1] | pub_hot[2];

    // Address phase; zero wait states, always OKAY
    s_d.wr_pend = 1'b0;
    s_d.rdata = '0;
    s_d.ready = 1'b1;
    s_d.resp = power_mode_pkg::HRESP_OKAY;
    if (addr_phase && hwrite) begin
      s_d.wr_pend = 1'b1;
      s_d.wr_addr = haddr[power_mode_pkg::ADDR_W-1:0];
    end else if (addr_phase) begin
      case (haddr[power_mode_pkg::ADDR_W-1:0])
        power_mode_pkg::OFS_FIXED_SUB: begin
          rd = power_mode_pkg::cfg_to_word(s_q.sub[power_mode_pkg::SUB_FIXED]);
        end
        power_mode_pkg::OFS_VAR_SUB: begin
          rd = power_mode_pkg::cfg_to_word(s_q.sub[power_mode_pkg::SUB_VAR]);
        end
        power_mode_pkg::OFS_SUPPLY_EV: begin
          rd[power_mode_pkg::EVENT_BIT] = s_q.ev[power_mode_pkg::EV_SUPPLY];
        end
        power_mode_pkg::OFS_ENTRY_EV: begin
          rd[power_mode_pkg::EVENT_BIT] = s_q.ev[power_mode_pkg::EV_ENTRY];
        end
        power_mode_pkg::OFS_EXIT_EV: begin
          rd[power_mode_pkg::EVENT_BIT] = s_q.ev[power_mode_pkg::EV_EXIT];
        end
        power_mode_pkg::OFS_SUPPLY_PUB: begin
          rd = power_mode_pkg::cfg_to_word(s_q.pub[power_mode_pkg::EV_SUPPLY]);
        end
        power_mode_pkg::OFS_ENTRY_PUB: begin
          rd = power_mode_pkg::cfg_to_word(s_q.pub[power_mode_pkg::EV_ENTRY]);
        end
        power_mode_pkg::OFS_EXIT_PUB: begin
          rd = power_mode_pkg::cfg_to_word(s_q.pub[power_mode_pkg::EV_EXIT]);
        end
        power_mode_pkg::OFS_IRQ_EN,
        power_mode_pkg::OFS_IRQ_SET,
        power_mode_pkg::OFS_IRQ_CLR: rd[2:0] = s_q.irq_en;
        default: ;
      endcase
      for (int i = 0; i < power_mode_pkg::SCRATCH_COUNT; i++) begin
        if (haddr[power_mode_pkg::ADDR_W-1:0] == scratch_ofs(i)) begin
          rd = scratch_q[i];
        end
      end
      s_d.rdata = rd;
    end
  end

  // Configuration and events clear on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
      s_q.sub <= {power_mode_pkg::SUB_COUNT{power_mode_pkg::CFG_RESET}};
      s_q.pub <= {power_mode_pkg::EVENT_COUNT{power_mode_pkg::CFG_RESET}};
      s_q.ev <= power_mode_pkg::EVENT_RESET;
      s_q.irq_en <= power_mode_pkg::IRQ_EN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge hclk or negedge retain_resetn) begin
    if (!retain_resetn) begin
      for (int i = 0; i < power_mode_pkg::SCRATCH_COUNT; i++) begin
        scratch_q[i] <= power_mode_pkg::SCRATCH_RESET;
      end
    end else begin
      for (int i = 0; i < power_mode_pkg::SCRATCH_COUNT; i++) begin
        if (s_q.wr_pend && s_q.wr_addr == scratch_ofs(i)) begin
          scratch_q[i] <= hwdata;
        end
      end
    end
  end

  assign hreadyout = s_q.ready;
  assign hresp = s_q.resp;
  assign hrdata = s_q.rdata;
  assign fixed_latency_request_q = s_q.fixed_req;
  assign mode_fixed_latency_q = s_q.mode_fixed;
  assign irq_q = s_q.irq;
  assign publish_channels_q = s_q.pub_chan;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence task_write(logic [11:0] ofs);
    s_q.wr_pend && s_q.wr_addr == ofs && hwdata[power_mode_pkg::TASK_BIT];
  endsequence

  sequence warn_read;
    addr_phase && !hwrite &&
      haddr[power_mode_pkg::ADDR_W-1:0] == power_mode_pkg::OFS_SUPPLY_EV;
  endsequence

  property p_fixed_task;
    task_write(power_mode_pkg::OFS_FIXED_TRIG) |=> fixed_latency_request_q;
  endproperty
  a_fixed_task: assert property (p_fixed_task)
    else $error("fixed latency task write not taken");

  property p_var_task;
    task_write(power_mode_pkg::OFS_VAR_TRIG) ##0 !go_fixed
      |=> !fixed_latency_request_q;
  endproperty
  a_var_task: assert property (p_var_task)
    else $error("variable latency task did not drop request");

  property p_sub_fixed;
    sub_hit[power_mode_pkg::SUB_FIXED] |=> fixed_latency_request_q;
  endproperty
  a_sub_fixed: assert property (p_sub_fixed)
    else $error("subscribed fixed latency pulse missed");

  property p_sub_idle;
    !s_q.sub[power_mode_pkg::SUB_FIXED].en &&
      !s_q.sub[power_mode_pkg::SUB_VAR].en && !s_q.wr_pend
      |=> $stable(fixed_latency_request_q);
  endproperty
  a_sub_idle: assert property (p_sub_idle)
    else $error("request moved with subscriptions disabled");

  property p_grant;
    ##1 mode_fixed_latency_q ==
      (fixed_latency_request_q || $past(peer_fixed_latency_request));
  endproperty
  a_grant: assert property (p_grant)
    else $error("fixed latency not granted for a request");

  property p_warn_gate;
    $rose(s_q.ev[power_mode_pkg::EV_SUPPLY]) |->
      $past(s_q.en_s2) || $past(s_q.wr_pend);
  endproperty
  a_warn_gate: assert property (p_warn_gate)
    else $error("warning raised with comparator off");

  property p_warn_set;
    warn_seen |=> s_q.ev[power_mode_pkg::EV_SUPPLY] &&
      (irq_q || !s_q.irq_en[power_mode_pkg::EV_SUPPLY]);
  endproperty
  a_warn_set: assert property (p_warn_set)
    else $error("comparator warning not recorded");

  property p_publish;
    warn_seen && s_q.pub[power_mode_pkg::EV_SUPPLY].en |=>
      publish_channels_q[$past(s_q.pub[power_mode_pkg::EV_SUPPLY].idx)];
  endproperty
  a_publish: assert property (p_publish)
    else $error("warning not published on its channel");

  property p_sleep;
    (cpu_sleeping && !s_q.sleep_prev |=> s_q.ev[power_mode_pkg::EV_ENTRY]) and
      (!cpu_sleeping && s_q.sleep_prev |=> s_q.ev[power_mode_pkg::EV_EXIT]);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep event not recorded");

  property p_irq;
    irq_q == |(s_q.ev & s_q.irq_en);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow enabled events");

  property p_set_alias;
    s_q.wr_pend && s_q.wr_addr == power_mode_pkg::OFS_IRQ_SET |=>
      (s_q.irq_en & $past(hwdata[2:0])) == $past(hwdata[2:0]) &&
      (s_q.irq_en & $past(s_q.irq_en)) == $past(s_q.irq_en);
  endproperty
  a_set_alias: assert property (p_set_alias)
    else $error("set alias cleared or missed an enable");

  property p_warn_read;
    warn_read |=> hrdata[0] == $past(s_q.ev[power_mode_pkg::EV_SUPPLY]) &&
      hrdata[31:1] == '0 && hreadyout;
  endproperty
  a_warn_read: assert property (p_warn_read)
    else $error("warning event readback wrong");

endmodule // power_mode_request_event_regs
